// ==== rtl/peripheral_input_remap.v ====
// Remappable pin select unit: APB registers, lock gating, input and output routing
`timescale 1ns/1ps
`default_nettype none
`include "pin_remap_defs.vh"

module peripheral_input_remap #(
    parameter NUM_PINS = 32
) (
    input wire ref_clk_i,
    input wire resetn_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [`ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // Remappable pins, asynchronous to ref_clk_i
    input wire [NUM_PINS-1:0] remappable_pin_i,
    // Peripheral outputs feeding pins 2 and 3
    input wire serial1_transmit_output_i,
    input wire serial1_request_to_send_output_i,
    // Routed peripheral inputs
    output wire external_interrupt_1_o,
    output wire external_interrupt_2_o,
    output wire timer2_ext_clock_o,
    output wire timer3_ext_clock_o,
    output wire timer4_ext_clock_o,
    output wire timer5_ext_clock_o,
    output wire capture_input_1_o,
    output wire capture_input_2_o,
    output wire capture_input_3_o,
    output wire capture_input_4_o,
    output wire serial1_receive_input_o,
    output wire serial1_clear_to_send_input_o,
    // Routed pin outputs
    output reg remappable_pin2_o,
    output reg remappable_pin3_o,
    // Lock state for the rest of the chip
    output reg remap_lock_bit_o
);

    // ----------------------------------------------------------------
    // Field map
    // ----------------------------------------------------------------
    // Index order: ext int 1, ext int 2, timer 2..5, capture 1..4,
    // serial1 rx, serial1 cts, pin 2 function, pin 3 function.
    function [`ADDR_W-1:0] field_addr;
        input integer idx;
        begin
            case (idx)
                0: field_addr = `OFS_EXT_EXTERNAL_INTERRUPT_1_SEL;
                1: field_addr = `OFS_EXT_EXTERNAL_INTERRUPT_2_SEL;
                2: field_addr = `OFS_TIMER23_SEL;
                3: field_addr = `OFS_TIMER23_SEL;
                4: field_addr = `OFS_TIMER45_SEL;
                5: field_addr = `OFS_TIMER45_SEL;
                6: field_addr = `OFS_CAPTURE12_SEL;
                7: field_addr = `OFS_CAPTURE12_SEL;
                8: field_addr = `OFS_CAPTURE34_SEL;
                9: field_addr = `OFS_CAPTURE34_SEL;
                10: field_addr = `OFS_SERIAL1_SEL;
                11: field_addr = `OFS_SERIAL1_SEL;
                12: field_addr = `OFS_PINS23_OUT_SEL;
                13: field_addr = `OFS_PINS23_OUT_SEL;
                default: field_addr = `OFS_OSC_CTRL;
            endcase
        end
    endfunction

    function integer field_lsb;
        input integer idx;
        begin
            case (idx)
                0: field_lsb = `FIELD_HI_LSB;
                1: field_lsb = `FIELD_LO_LSB;
                2: field_lsb = `FIELD_LO_LSB;
                3: field_lsb = `FIELD_HI_LSB;
                4: field_lsb = `FIELD_LO_LSB;
                5: field_lsb = `FIELD_HI_LSB;
                6: field_lsb = `FIELD_LO_LSB;
                7: field_lsb = `FIELD_HI_LSB;
                8: field_lsb = `FIELD_LO_LSB;
                9: field_lsb = `FIELD_HI_LSB;
                10: field_lsb = `FIELD_LO_LSB;
                11: field_lsb = `FIELD_HI_LSB;
                12: field_lsb = `FIELD_LO_LSB;
                13: field_lsb = `FIELD_HI_LSB;
                default: field_lsb = `FIELD_LO_LSB;
            endcase
        end
    endfunction

    // Byte lane that carries a field
    function lane_strobe;
        input integer idx;
        input [3:0] strb;
        begin
            if (field_lsb(idx) == `FIELD_HI_LSB) begin
                lane_strobe = strb[1];
            end else begin
                lane_strobe = strb[0];
            end
        end
    endfunction

    function addr_mapped;
        input [`ADDR_W-1:0] addr;
        begin
            case (addr)
                `OFS_OSC_CTRL,
                `OFS_REMAP_INFO,
                `OFS_EXT_EXTERNAL_INTERRUPT_1_SEL,
                `OFS_EXT_EXTERNAL_INTERRUPT_2_SEL,
                `OFS_TIMER23_SEL,
                `OFS_TIMER45_SEL,
                `OFS_CAPTURE12_SEL,
                `OFS_CAPTURE34_SEL,
                `OFS_SERIAL1_SEL,
                `OFS_PINS23_OUT_SEL: addr_mapped = 1'b1;
                default: addr_mapped = 1'b0;
            endcase
        end
    endfunction

    // Pin function decode; unknown codes give the null output
    function drive_func;
        input [`FIELD_W-1:0] code;
        input tx;
        input rts;
        begin
            case (code)
                `FUNC_SERIAL1_TX: drive_func = tx;
                `FUNC_SERIAL1_RTS: drive_func = rts;
                default: drive_func = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // APB handshake
    // ----------------------------------------------------------------
    reg [`FIELD_W-1:0] field_sel [0:`NUM_FIELDS-1];
    reg [31:0] rd_word;
    wire apb_setup;
    wire apb_fire;
    wire wr_fire;
    integer k;

    assign apb_setup = psel_i & ~penable_i & ~pready_o;
    assign apb_fire = psel_i & penable_i & pready_o;
    assign wr_fire = apb_fire & pwrite_i;

    // One wait-free access: pready rises at the setup edge, falls after the access edge
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else if (apb_setup) begin
            pready_o <= 1'b1;
            pslverr_o <= ~addr_mapped(paddr_i);
            prdata_o <= pwrite_i ? 32'h00000000 : rd_word;
        end else if (apb_fire) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Unimplemented bits stay zero because only fields are placed
    always @* begin
        rd_word = 32'h00000000;
        for (k = 0; k < `NUM_FIELDS; k = k + 1) begin
            if (paddr_i == field_addr(k)) begin
                rd_word[field_lsb(k) +: `FIELD_W] = field_sel[k];
            end
        end
        if (paddr_i == `OFS_OSC_CTRL) begin
            rd_word[`LOCK_BIT] = remap_lock_bit_o;
        end
        if (paddr_i == `OFS_REMAP_INFO) begin
            rd_word[`INFO_IN_LSB +: `INFO_CNT_W] = `NUM_IN_REGS;
            rd_word[`INFO_OUT_LSB +: `INFO_CNT_W] = `NUM_OUT_REGS;
        end
    end

    // ----------------------------------------------------------------
    // Lock bit
    // ----------------------------------------------------------------
    // The unlock key sequence is left to the oscillator block upstream;
    // here a plain write to the lock bit takes effect.
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            remap_lock_bit_o <= `LOCK_RESET;
        end else if (wr_fire && paddr_i == `OFS_OSC_CTRL && pstrb_i[0]) begin
            remap_lock_bit_o <= pwdata_i[`LOCK_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Select fields
    // ----------------------------------------------------------------
    // Lock gating sits in one place so every field bounces alike
    wire field_wr_ok;
    wire [`NUM_FIELDS-1:0] field_we;
    integer m;
    genvar w;

    assign field_wr_ok = wr_fire & ~remap_lock_bit_o;

    generate
        for (w = 0; w < `NUM_FIELDS; w = w + 1) begin : g_field_we
            assign field_we[w] = field_wr_ok && (paddr_i == field_addr(w))
                && lane_strobe(w, pstrb_i);
        end
    endgenerate

    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            for (m = 0; m < `NUM_FIELDS; m = m + 1) begin
                field_sel[m] <= `FIELD_RESET;
            end
        end else begin
            for (m = 0; m < `NUM_FIELDS; m = m + 1) begin
                if (field_we[m]) begin
                    field_sel[m] <= pwdata_i[field_lsb(m) +: `FIELD_W];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin input synchroniser
    // ----------------------------------------------------------------
    // Three stages; a level is taken once stages two and three agree,
    // which also rejects a single-cycle glitch.
    reg [NUM_PINS-1:0] pin_s1;
    reg [NUM_PINS-1:0] pin_s2;
    reg [NUM_PINS-1:0] pin_s3;
    reg [NUM_PINS-1:0] pin_level;

    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pin_s1 <= {NUM_PINS{1'b0}};
            pin_s2 <= {NUM_PINS{1'b0}};
            pin_s3 <= {NUM_PINS{1'b0}};
            pin_level <= {NUM_PINS{1'b0}};
        end else begin
            pin_s1 <= remappable_pin_i;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_level <= (pin_s2 & pin_s3) | (pin_level & (pin_s2 | pin_s3));
        end
    end

    // ----------------------------------------------------------------
    // Peripheral input routing
    // ----------------------------------------------------------------
    wire [`NUM_IN_FIELDS-1:0] routed_in;

    genvar g;
    generate
        for (g = 0; g < `NUM_IN_FIELDS; g = g + 1) begin : g_in_mux
            pin_select_mux #(
                .NUM_PINS(NUM_PINS)
            ) u_mux (
                .ref_clk_i(ref_clk_i),
                .resetn_i(resetn_i),
                .pins_i(pin_level),
                .sel_i(field_sel[g]),
                .sel_o(routed_in[g])
            );
        end
    endgenerate

    assign external_interrupt_1_o = routed_in[0];
    assign external_interrupt_2_o = routed_in[1];
    assign timer2_ext_clock_o = routed_in[2];
    assign timer3_ext_clock_o = routed_in[3];
    assign timer4_ext_clock_o = routed_in[4];
    assign timer5_ext_clock_o = routed_in[5];
    assign capture_input_1_o = routed_in[6];
    assign capture_input_2_o = routed_in[7];
    assign capture_input_3_o = routed_in[8];
    assign capture_input_4_o = routed_in[9];
    assign serial1_receive_input_o = routed_in[10];
    assign serial1_clear_to_send_input_o = routed_in[11];

    // ----------------------------------------------------------------
    // Pin output routing
    // ----------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            remappable_pin2_o <= 1'b0;
            remappable_pin3_o <= 1'b0;
        end else begin
            remappable_pin2_o <= drive_func(field_sel[`FLD_PIN2_OUT],
                serial1_transmit_output_i, serial1_request_to_send_output_i);
            remappable_pin3_o <= drive_func(field_sel[`FLD_PIN3_OUT],
                serial1_transmit_output_i, serial1_request_to_send_output_i);
        end
    end

endmodule // peripheral_input_remap

`default_nettype wire

// ==== rtl/pin_remap_defs.vh ====
// Constants for the peripheral input remap block
//
// Functional notes
// - Remap select registers accept writes only while the remap lock bit is 0.
// - Unit reports 27 configuration registers: 14 input selects, 13 output selects.
// - Input select field value n feeds the peripheral input from remappable pin n.
// - Output function code 3 drives serial1 transmit, code 4 drives request-to-send.
// - Register 0 holds external interrupt 1 select in bits 12-8; rest read zero.
// - Register 1 holds external interrupt 2 select in bits 4-0; rest read zero.
// - Register 3 holds timer3 clock select 12-8, timer2 clock select 4-0.
// - Register 4 holds timer5 clock select 12-8, timer4 clock select 4-0.
// - Register 7 holds capture 2 select 12-8, capture 1 select 4-0.
// - Register 8 holds capture 4 select 12-8, capture 3 select 4-0.
// - Every select bit is read/write and resets to one.
// - Remap lock bit resets cleared, so selects are writable after reset.
`ifndef PIN_REMAP_DEFS_VH
`define PIN_REMAP_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADDR_W 12
`define OFS_OSC_CTRL 12'h000
`define OFS_REMAP_INFO 12'h004
`define OFS_EXT_EXTERNAL_INTERRUPT_1_SEL 12'h010
`define OFS_EXT_EXTERNAL_INTERRUPT_2_SEL 12'h014
`define OFS_TIMER23_SEL 12'h01C
`define OFS_TIMER45_SEL 12'h020
`define OFS_CAPTURE12_SEL 12'h02C
`define OFS_CAPTURE34_SEL 12'h030
`define OFS_SERIAL1_SEL 12'h058
`define OFS_PINS23_OUT_SEL 12'h080

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define FIELD_W 5
`define FIELD_LO_LSB 0
`define FIELD_HI_LSB 8
`define FIELD_RESET 5'h1F
`define LOCK_BIT 6
`define LOCK_RESET 1'h0
`define INFO_IN_LSB 0
`define INFO_OUT_LSB 8
`define INFO_CNT_W 8
`define NUM_IN_REGS 8'h0E
`define NUM_OUT_REGS 8'h0D

// ----------------------------------------------------------------
// Field indices and output function codes
// ----------------------------------------------------------------
`define NUM_FIELDS 14
`define NUM_IN_FIELDS 12
`define FLD_PIN2_OUT 12
`define FLD_PIN3_OUT 13
`define FUNC_SERIAL1_TX 5'h03
`define FUNC_SERIAL1_RTS 5'h04

`endif

// ==== rtl/pin_select_mux.v ====
// Registered pin selector for one peripheral input
`timescale 1ns/1ps
`default_nettype none
`include "pin_remap_defs.vh"

module pin_select_mux #(
    parameter NUM_PINS = 32
) (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire [NUM_PINS-1:0] pins_i,
    input wire [`FIELD_W-1:0] sel_i,
    output reg sel_o
);

    // Selects past the last pin read as zero
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sel_o <= 1'b0;
        end else if (sel_i < NUM_PINS) begin
            sel_o <= pins_i[sel_i];
        end else begin
            sel_o <= 1'b0;
        end
    end

endmodule // pin_select_mux

`default_nettype wire

// ==== verification/peripheral_input_remap_tb.sv ====
// Self-checking bench for the peripheral input remap block
`timescale 1ns/1ps
`default_nettype none
`include "pin_remap_defs.vh"

module peripheral_input_remap_tb;
    logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [`ADDR_W-1:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, rv, pins = 0;
    logic [3:0] pstrb = 0;
    logic pready, pslverr, err, tx = 0, rts = 0, pin2, pin3, lock_o, lock;
    wire logic [11:0] routed;
    int bad_count = 0, compares = 0, r, fld[14], hi[8], lo[8];
    integer seed = 32'hb90945a7;
    logic [11:0] ra[8];

    always #50 ref_clk = ~ref_clk;

    peripheral_input_remap #(.NUM_PINS(32)) u_peripheral_input_remap (
        .ref_clk_i(ref_clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .remappable_pin_i(pins),
        .serial1_transmit_output_i(tx), .serial1_request_to_send_output_i(rts),
        .external_interrupt_1_o(routed[0]), .external_interrupt_2_o(routed[1]),
        .timer2_ext_clock_o(routed[2]), .timer3_ext_clock_o(routed[3]),
        .timer4_ext_clock_o(routed[4]), .timer5_ext_clock_o(routed[5]),
        .capture_input_1_o(routed[6]), .capture_input_2_o(routed[7]),
        .capture_input_3_o(routed[8]), .capture_input_4_o(routed[9]),
        .serial1_receive_input_o(routed[10]), .serial1_clear_to_send_input_o(routed[11]),
        .remappable_pin2_o(pin2), .remappable_pin3_o(pin3), .remap_lock_bit_o(lock_o));

    // ------------------------------------------------
    // Model and bus tasks
    // ------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    function automatic logic [31:0] expv(int i);
        expv = 0;
        if (hi[i] >= 0) expv[12:8] = fld[hi[i]];
        if (lo[i] >= 0) expv[4:0] = fld[lo[i]];
    endfunction

    task automatic wr(int i, logic [31:0] d, logic [3:0] s);
        apb(1, ra[i], d, s);
        if (!lock && s[0] && lo[i] >= 0) fld[lo[i]] = d[4:0];
        if (!lock && s[1] && hi[i] >= 0) fld[hi[i]] = d[12:8];
    endtask

    task automatic rdchk(int i);
        apb(0, ra[i], 0, 0);
        chk(rd, expv(i));
        chk(err, 0);
    endtask

    task automatic route_chk;
        logic [13:0] e;
        repeat (6) @(posedge ref_clk);
        for (int i = 0; i < 12; i++) e[i] = pins[fld[i]];
        e[12] = fld[12] == 3 ? tx : fld[12] == 4 ? rts : 1'b0;
        e[13] = fld[13] == 3 ? tx : fld[13] == 4 ? rts : 1'b0;
        chk({pin3, pin2, routed}, e);
        chk(lock_o, lock);
    endtask

    task automatic setlock(logic v);
        apb(1, `OFS_OSC_CTRL, {25'h0, v, 6'h0}, 4'h1);
        lock = v;
    endtask

    task automatic check_all;
        apb(0, `OFS_OSC_CTRL, 0, 0);
        chk(rd, {25'h0, lock, 6'h0});
        apb(0, `OFS_REMAP_INFO, 0, 0);
        chk(rd, 32'h00000D0E);
        for (int i = 0; i < 8; i++) rdchk(i);
        route_chk();
    endtask

    task automatic print_verdict;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------
    // Sequence
    // ------------------------------------------------
    initial begin
        ra = '{`OFS_EXT_EXTERNAL_INTERRUPT_1_SEL, `OFS_EXT_EXTERNAL_INTERRUPT_2_SEL, `OFS_TIMER23_SEL, `OFS_TIMER45_SEL,
               `OFS_CAPTURE12_SEL, `OFS_CAPTURE34_SEL, `OFS_SERIAL1_SEL, `OFS_PINS23_OUT_SEL};
        hi = '{0, -1, 3, 5, 7, 9, 11, 13};
        lo = '{-1, 1, 2, 4, 6, 8, 10, 12};
        foreach (fld[i]) fld[i] = 31;
        lock = 0;
        repeat (5) @(posedge ref_clk);
        resetn <= 1;
        check_all();
        tx <= 1;
        wr(7, 32'h0403, 4'h3);
        route_chk();
        wr(7, 32'h0304, 4'h3);
        route_chk();
        // Lock is set for the middle third, so those writes must bounce
        for (int k = 0; k < 24; k++) begin
            if (k % 8 == 0) setlock(k == 8);
            pins <= $random(seed);
            rv = $random(seed);
            tx <= rv[0];
            rts <= rv[1];
            r = rv[10:8] % 8;
            wr(r, $random(seed), rv[7:4]);
            rdchk(r);
            route_chk();
        end
        apb(0, 12'h0FC, 0, 0);
        chk(err, 1);
        chk(rd, 0);
        setlock(1);
        resetn <= 0;
        repeat (5) @(posedge ref_clk);
        resetn <= 1;
        foreach (fld[i]) fld[i] = 31;
        lock = 0;
        check_all();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        print_verdict();
    end
endmodule // peripheral_input_remap_tb
`default_nettype wire

// ==== verification/remap_properties.sv ====
// Assertions for the peripheral input remap block
`timescale 1ns/1ps
`default_nettype none
`include "pin_remap_defs.vh"

module remap_properties (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic remap_lock_bit_o
);
    logic acc;
    logic rd;
    logic wr_lock;
    assign acc = psel_i && penable_i && pready_o;
    assign rd = acc && !pwrite_i;
    assign wr_lock = acc && pwrite_i && paddr_i == `OFS_OSC_CTRL;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    setup_ready_a:
        assert property (psel_i && !penable_i && !pready_o |=> pready_o)
        else $error("ready missing after setup");
    ready_pulse_a:
        assert property (pready_o |=> !pready_o) else $error("ready held too long");
    lock_reset_a:
        assert property ($rose(resetn_i) |-> !remap_lock_bit_o && !pready_o)
        else $error("lock set after reset");
    lock_write_a:
        assert property (wr_lock && pstrb_i[0] |=> remap_lock_bit_o == $past(pwdata_i[6]))
        else $error("lock write lost");
    lock_hold_a:
        assert property (!wr_lock |=> $stable(remap_lock_bit_o)) else $error("lock moved");
    info_read_a:
        assert property (rd && paddr_i == `OFS_REMAP_INFO |-> prdata_o == 32'h00000D0E)
        else $error("bad register count");
    ext1_bits_a:
        assert property (rd && paddr_i == `OFS_EXT_EXTERNAL_INTERRUPT_1_SEL
            |-> prdata_o[7:0] == 8'h00 && prdata_o[31:13] == 19'h0)
        else $error("ext external_interrupt_1 spare bits set");
    ext2_bits_a:
        assert property (rd && paddr_i == `OFS_EXT_EXTERNAL_INTERRUPT_2_SEL |-> prdata_o[31:5] == 27'h0)
        else $error("ext external_interrupt_2 spare bits set");
    pair_bits_a:
        assert property (rd && paddr_i inside {`OFS_TIMER23_SEL, `OFS_TIMER45_SEL,
            `OFS_CAPTURE12_SEL, `OFS_CAPTURE34_SEL}
            |-> prdata_o[7:5] == 3'h0 && prdata_o[31:13] == 19'h0)
        else $error("pair spare bits set");
    cover property (wr_lock && pwdata_i[6]);
    cover property (acc && pslverr_o);
    cover property (rd && paddr_i == `OFS_REMAP_INFO);
endmodule // remap_properties

bind peripheral_input_remap remap_properties u_remap_properties (.ref_clk_i, .resetn_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
    .pslverr_o, .remap_lock_bit_o);
`default_nettype wire
